// File: fcg_clock_control.sv
// clock generator control: mode sequencing, loop ratios and registers
//
// Summary of operation
// RULE1 - high gain bit picks low power or high gain; first write only.
// RULE2 - range bit: low band prescale 64, high band prescale 1; write-once.
// RULE3 - range matters only in the two external reference modes.
// RULE4 - reference type bit: 0 external clock, 1 crystal; write-once.
// RULE5 - mode field: 00 self, 01 FLL internal, 10 bypass ext, 11 FLL ext.
// RULE6 - bypass external mode not entered until external status reads 1.
// RULE7 - entering off mode leaves the programmed mode field unchanged.
// RULE8 - mode writes ignored while a previous mode change is unfinished.
// RULE9 - first mode write 0X locks out later 1X writes until reset.
// RULE10 - multiplier field decodes 4,6,8,10,12.
// RULE11 - divider field decodes 1,2,4,8,16.
// RULE12 - FLL external output is external times P times N over R.
// RULE13 - FLL internal output is internal over 7 times 64 times N over R.
// RULE14 - self mode is loop clock over R; bypass is external over R.
// RULE15 - per mode power: reference generator, loop oscillator, open loop.
// RULE16 - after reset the generator runs self-clocked.
// RULE17 - while external reference pending, keep clocking from old source.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
module fcg_clock_control
    import fcg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // status from the external reference and the power controller
    input wire logic extRefClockStatus,
    input wire logic genOffRequest,
    // clock generator controls
    output logic [1:0] activeMode,
    output logic useExtSource,
    output logic intRefEnable,
    output logic loopOscEnable,
    output logic loopOscOpen,
    output logic oscEnable,
    output logic oscHighGain,
    output logic oscHighRange,
    output logic oscCrystal,
    output logic [10:0] ratioNum,
    output logic [6:0] ratioDen
);

    ////////////////////////////////////////////////////////////////////
    // register state

    logic highGainSelect;
    logic rangeSelect;
    logic extRefTypeSelect;
    logic [1:0] clockModeSelect;
    logic [2:0] loopMultiplierField;
    logic [2:0] outputDividerField;
    logic onceWritten;
    logic modeWritten;
    logic extLocked;
    logic extRefSync;
    fcg_switch_t swState;

    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0] wByte;
    logic wLane;
    logic doWrite;
    logic wrCtrl1;
    logic wrCtrl2;
    logic modeBusy;
    logic [1:0] newMode;
    logic modeAccept;

    // external status comes from the oscillator domain
    fcg_sync2 #(.WIDTH(1)) extRefSyncer (
        .clk(clk),
        .reset_n(reset_n),
        .asyncIn(extRefClockStatus),
        .syncOut(extRefSync)
    );

    ////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign wrCtrl1 = doWrite && wLane && (awAddr == ADDR_CTRL1);
    assign wrCtrl2 = doWrite && wLane && (awAddr == ADDR_CTRL2);
    assign newMode = wByte[MODE_HI:MODE_LO];
    assign modeBusy = (swState != SW_STEADY);
    // a refused mode write still completes on the bus with OKAY
    assign modeAccept = wrCtrl1 && !modeBusy //RULE8
        && !(extLocked && newMode[1]); //RULE9

    // hold address and data until both have arrived
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wByte <= 8'h00;
            wLane <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wByte <= s_axi_wdata[7:0];
                wLane <= s_axi_wstrb[0];
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // write response, error for an unmapped or read-only address
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr == ADDR_CTRL1 || awAddr == ADDR_CTRL2)
                ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register fields

    // write-once bits: the first write after reset wins, later ones drop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            highGainSelect <= CTRL1_RESET[GAIN_BIT];
            rangeSelect <= CTRL1_RESET[RANGE_BIT];
            extRefTypeSelect <= CTRL1_RESET[REFTYPE_BIT];
            onceWritten <= 1'b0;
        end else if (wrCtrl1 && !onceWritten) begin
            highGainSelect <= wByte[GAIN_BIT]; //RULE1
            rangeSelect <= wByte[RANGE_BIT]; //RULE2
            extRefTypeSelect <= wByte[REFTYPE_BIT]; //RULE4
            onceWritten <= 1'b1;
        end
    end

    // mode field; the off request never touches it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clockModeSelect <= CTRL1_RESET[MODE_HI:MODE_LO]; //RULE16
            modeWritten <= 1'b0;
            extLocked <= 1'b0;
        end else if (modeAccept) begin
            clockModeSelect <= newMode; //RULE7
            modeWritten <= 1'b1;
            if (!modeWritten && !newMode[1]) begin
                extLocked <= 1'b1; //RULE9
            end
        end
    end

    // loop multiplier and output divider, writable at any time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loopMultiplierField <= MULT_RESET;
            outputDividerField <= DIV_RESET;
        end else if (wrCtrl2) begin
            loopMultiplierField <= wByte[MULT_HI:MULT_LO];
            outputDividerField <= wByte[DIV_HI:DIV_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode switch sequencer

    // external modes wait for a valid reference; the old source stays
    // selected meanwhile so the output never sees a half-started clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            swState <= SW_STEADY;
            activeMode <= MODE_SELF; //RULE16
        end else begin
            case (swState)
                SW_STEADY: begin
                    if (clockModeSelect != activeMode) begin
                        swState <= SW_WAITREF;
                    end
                end
                SW_WAITREF: begin
                    if (!clockModeSelect[1] || extRefSync) begin //RULE6
                        swState <= SW_SWAP;
                    end
                end
                SW_SWAP: begin
                    activeMode <= clockModeSelect; //RULE17
                    swState <= SW_STEADY;
                end
                default: begin
                    swState <= SW_STEADY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // loop ratio decode

    function automatic logic [3:0] decodeMult(input logic [2:0] code);
        case (code)
            3'h0: decodeMult = 4'h4;
            3'h1: decodeMult = 4'h6;
            3'h2: decodeMult = 4'h8;
            3'h3: decodeMult = 4'hA;
            default: decodeMult = 4'hC;
        endcase
    endfunction : decodeMult

    function automatic logic [4:0] decodeDiv(input logic [2:0] code);
        case (code)
            3'h0: decodeDiv = 5'h01;
            3'h1: decodeDiv = 5'h02;
            3'h2: decodeDiv = 5'h04;
            3'h3: decodeDiv = 5'h08;
            default: decodeDiv = 5'h10;
        endcase
    endfunction : decodeDiv

    logic [3:0] multN;
    logic [4:0] divR;
    logic [6:0] prescaleP;
    logic [10:0] next_ratioNum;
    logic [6:0] next_ratioDen;

    assign multN = decodeMult(loopMultiplierField); //RULE10
    assign divR = decodeDiv(outputDividerField); //RULE11
    assign prescaleP = rangeSelect ? PRESCALE_HIGH : PRESCALE_LOW; //RULE2

    // output frequency over reference frequency, as numerator/denominator
    always_comb begin
        next_ratioNum = RATIO_ONE;
        next_ratioDen = {2'h0, divR};
        case (activeMode)
            MODE_EXTLOOP: begin
                next_ratioNum = 11'(prescaleP * multN); //RULE12
            end
            MODE_INTLOOP: begin
                next_ratioNum = 11'(INTREF_POSTMUL * multN); //RULE13
                next_ratioDen = 7'(INTREF_PREDIV * divR); //RULE13
            end
            default: begin
                next_ratioNum = RATIO_ONE; //RULE14
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // power and source controls, registered

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ratioNum <= RATIO_ONE;
            ratioDen <= 7'h01;
            useExtSource <= 1'b0;
            intRefEnable <= 1'b0;
            loopOscEnable <= 1'b1;
            loopOscOpen <= 1'b1;
            oscEnable <= 1'b0;
            oscHighGain <= 1'b0;
            oscHighRange <= 1'b0;
            oscCrystal <= 1'b0;
        end else begin
            ratioNum <= next_ratioNum;
            ratioDen <= next_ratioDen;
            useExtSource <= (activeMode == MODE_BYPASS); //RULE14
            // off mode gates power only; the field stays as programmed
            intRefEnable <= !genOffRequest && activeMode == MODE_INTLOOP; //RULE15
            loopOscEnable <= !genOffRequest && activeMode != MODE_BYPASS; //RULE15
            loopOscOpen <= (activeMode == MODE_SELF); //RULE15
            oscEnable <= !genOffRequest && activeMode[1];
            oscHighGain <= highGainSelect; //RULE1
            oscHighRange <= rangeSelect && activeMode[1]; //RULE3
            oscCrystal <= extRefTypeSelect; //RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel, answer one cycle after the address is taken

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL1: begin
                    s_axi_rdata[GAIN_BIT] <= highGainSelect;
                    s_axi_rdata[RANGE_BIT] <= rangeSelect;
                    s_axi_rdata[REFTYPE_BIT] <= extRefTypeSelect;
                    s_axi_rdata[MODE_HI:MODE_LO] <= clockModeSelect; //RULE5
                end
                ADDR_CTRL2: begin
                    s_axi_rdata[MULT_HI:MULT_LO] <= loopMultiplierField;
                    s_axi_rdata[DIV_HI:DIV_LO] <= outputDividerField;
                end
                ADDR_STATUS: begin
                    s_axi_rdata[ST_EXTREF_BIT] <= extRefSync;
                    s_axi_rdata[ST_BUSY_BIT] <= modeBusy;
                    s_axi_rdata[ST_MODE_HI:ST_MODE_LO] <= activeMode;
                    s_axi_rdata[ST_EXTLOCK_BIT] <= extLocked;
                end
                default: begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : fcg_clock_control

// File: fcg_pkg.sv
// shared constants and types for the clock generator control block
package fcg_pkg;

    // register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] ADDR_CTRL1 = 4'h0;
    localparam logic [3:0] ADDR_CTRL2 = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int ADDR_W = 4;

    // clock_gen_control_1 field positions
    localparam int GAIN_BIT = 7;
    localparam int RANGE_BIT = 6;
    localparam int REFTYPE_BIT = 5;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 3;

    // second control register: loop multiplier and output divider fields
    localparam int MULT_HI = 6;
    localparam int MULT_LO = 4;
    localparam int DIV_HI = 2;
    localparam int DIV_LO = 0;

    // status register field positions
    localparam int ST_EXTREF_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_MODE_LO = 2;
    localparam int ST_MODE_HI = 3;
    localparam int ST_EXTLOCK_BIT = 4;

    // reset values
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [2:0] MULT_RESET = 3'h0;
    localparam logic [2:0] DIV_RESET = 3'h0;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // clock modes as held in the mode field
    localparam logic [1:0] MODE_SELF = 2'h0;
    localparam logic [1:0] MODE_INTLOOP = 2'h1;
    localparam logic [1:0] MODE_BYPASS = 2'h2;
    localparam logic [1:0] MODE_EXTLOOP = 2'h3;

    // loop ratio constants
    localparam logic [6:0] PRESCALE_LOW = 7'h40;
    localparam logic [6:0] PRESCALE_HIGH = 7'h01;
    localparam logic [6:0] INTREF_PREDIV = 7'h07;
    localparam logic [6:0] INTREF_POSTMUL = 7'h40;
    localparam logic [10:0] RATIO_ONE = 11'h001;

    // mode switch sequencer
    typedef enum logic [2:0] {
        SW_STEADY = 3'b001,
        SW_WAITREF = 3'b010,
        SW_SWAP = 3'b100
    } fcg_switch_t;

endpackage : fcg_pkg

// File: fcg_sync2.sv
// two-flop synchroniser for a level arriving from outside the clock domain
module fcg_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule : fcg_sync2

// File: fcg_clock_control_asserts.sv
// port assertions for the clock generator control block
module fcg_clock_control_asserts
    import fcg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic extRefClockStatus,
    input wire logic genOffRequest,
    input wire logic [1:0] activeMode,
    input wire logic useExtSource,
    input wire logic intRefEnable,
    input wire logic loopOscEnable,
    input wire logic loopOscOpen,
    input wire logic oscEnable,
    input wire logic oscHighRange,
    input wire logic [10:0] ratioNum,
    input wire logic [6:0] ratioDen
);
    timeunit 1ns;
    timeprecision 100ps;
    // all checks sample the block clock and sleep during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////
    boot_self_a:
        assert property ($rose(reset_n) |-> activeMode == MODE_SELF
            && loopOscOpen && ratioNum == RATIO_ONE)
        else $error("not self clocked after reset");
    ext_source_a:
        assert property (useExtSource == ($past(activeMode) == MODE_BYPASS))
        else $error("external source select wrong");
    open_loop_a:
        assert property (loopOscOpen == ($past(activeMode) == MODE_SELF))
        else $error("open loop select wrong");
    refgen_gate_a:
        assert property (intRefEnable == ($past(activeMode) == MODE_INTLOOP
            && !$past(genOffRequest)))
        else $error("reference generator enable wrong");
    osc_gate_a:
        assert property (oscEnable == ($past(activeMode[1])
            && !$past(genOffRequest)))
        else $error("oscillator enable wrong");
    loop_osc_gate_a:
        assert property (loopOscEnable == ($past(activeMode) != MODE_BYPASS
            && !$past(genOffRequest)))
        else $error("loop oscillator enable wrong");
    range_scope_a:
        assert property (oscHighRange |-> $past(activeMode[1]))
        else $error("range applied in internal mode");
    ext_entry_a:
        assert property (activeMode[1] && !$past(activeMode[1])
            |-> $past(extRefClockStatus, 2))
        else $error("external mode entered without reference");
    int_ratio_a:
        assert property ($past(activeMode) == MODE_INTLOOP |->
            ratioNum[5:0] == 6'h00 && ratioDen % 7 == 0)
        else $error("internal loop ratio wrong");
    plain_div_a:
        assert property (!$past(activeMode[0]) |-> ratioNum == RATIO_ONE
            && $onehot(ratioDen) && ratioDen <= 7'h10)
        else $error("divide only ratio wrong");
endmodule : fcg_clock_control_asserts

// File: fcg_ext_ref.sv
// external reference source: status valid some cycles after start
module fcg_ext_ref
    import fcg_pkg::*;
(
    input wire logic clk,
    input wire logic refOn,
    input wire logic slow,
    output logic extRefClockStatus
);
    timeunit 1ns;
    timeprecision 100ps;
    int count = 0;
    // startup count restarts whenever the source is switched off
    always @(posedge clk) begin
        if (!refOn) count <= 0;
        else if (count < 40) count <= count + 1;
    end
    // off-edge change, the real source has no phase tie to our clock
    // clocked so the status is known from the first edge, never unknown
    always @(posedge clk) begin
        extRefClockStatus <= #3 (count >= (slow ? 30 : 2));
    end
endmodule : fcg_ext_ref

// File: fcg_clock_control_bench.sv
// self-checking bench for the clock generator control block
module fcg_clock_control_bench
    import fcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, reset_n = 1'h0, genOffRequest = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic refOn = 1'h0, slow = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, extRefClockStatus;
    logic [1:0] s_axi_bresp, s_axi_rresp, activeMode, lastResp;
    logic useExtSource, intRefEnable, loopOscEnable, loopOscOpen, oscEnable;
    logic oscHighGain, oscHighRange, oscCrystal;
    logic [10:0] ratioNum;
    logic [6:0] ratioDen;
    int fails = 0, checks_done = 0, cyc = 0;
    // packed views of the controls and the ratio for one-line compares
    wire logic [9:0] ctl = {activeMode, useExtSource, intRefEnable,
        loopOscEnable, loopOscOpen, oscEnable, oscHighGain, oscHighRange,
        oscCrystal};
    wire logic [17:0] rat = {ratioNum, ratioDen};

    fcg_clock_control dut_u (.*);
    fcg_ext_ref ref_u (.*);

    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic rst;
        reset_n <= 1'h0;
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
    endtask : rst
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
        input logic [1:0] e);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'h1;
        s_axi_wdata <= {24'h0, d};
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'h0;
        if (n == 50) fails++;
        chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'h0;
        if (n == 50) fails++;
        d = s_axi_rdata;
        lastResp = s_axi_rresp;
    endtask : rd
    task automatic rck(input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        rd(a, d);
        chk("rdata", e, d & m);
        chk("rresp", {30'h0, er}, {30'h0, lastResp});
    endtask : rck
    // polls busy; outputs trail the mode by a clock so wait two more
    task automatic idle;
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(ADDR_STATUS, d);
            n++;
        end while (d[ST_BUSY_BIT] !== 1'h0 && n < 100);
        if (n == 100) fails++;
        repeat (2) @(posedge clk);
    endtask : idle

    ////////////////////////////////////////////////////////////
    initial begin
        rst;
        // reset state and plain register access
        chk("ctl", 10'h030, ctl);
        chk("ratio", {11'h001, 7'h01}, rat);
        rck(ADDR_CTRL1, 32'hFF, 32'h00, RESP_OKAY);
        rck(ADDR_CTRL2, 32'hFF, 32'h00, RESP_OKAY);
        rck(4'hC, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 8'hFF, RESP_SLVERR);
        // a write with byte lane 0 off changes nothing
        s_axi_wstrb <= 4'hE;
        wr(ADDR_CTRL2, 8'h44, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rck(ADDR_CTRL2, 32'hFF, 32'h00, RESP_OKAY);
        // internal reference loop with multiplier and divider codes 0 to 4
        wr(ADDR_CTRL1, 8'hE8, RESP_OKAY);
        idle;
        chk("ctl", 10'h165, ctl);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL2, 8'(i * 17), RESP_OKAY);
            @(posedge clk);
            chk("ratio", {11'(64 * (4 + 2 * i)), 7'(7 << i)}, rat);
        end
        wr(ADDR_CTRL1, 8'h18, RESP_OKAY);
        rck(ADDR_CTRL1, 32'hFF, 32'hE8, RESP_OKAY);
        wr(ADDR_CTRL1, 8'h00, RESP_OKAY);
        idle;
        chk("ctl", 10'h035, ctl);
        chk("ratio", {11'h001, 7'h10}, rat);
        rck(ADDR_STATUS, 32'h1F, 32'h10, RESP_OKAY);
        // switching the generator off keeps the programmed mode
        genOffRequest <= 1'h1;
        repeat (3) @(posedge clk);
        chk("ctl", 10'h015, ctl);
        rck(ADDR_CTRL1, 32'hFF, 32'hE0, RESP_OKAY);
        genOffRequest <= 1'h0;
        // slow reference: pending switch, dropped write, then bypass
        slow <= 1'h1;
        rst;
        wr(ADDR_CTRL1, 8'h18, RESP_OKAY);
        repeat (4) @(posedge clk);
        rck(ADDR_STATUS, 32'h0E, 32'h02, RESP_OKAY);
        wr(ADDR_CTRL1, 8'h00, RESP_OKAY);
        chk("ctl", 10'h030, ctl);
        refOn <= 1'h1;
        idle;
        chk("ctl", 10'h328, ctl);
        chk("ratio", {11'h100, 7'h01}, rat);
        rck(ADDR_CTRL1, 32'hFF, 32'h18, RESP_OKAY);
        wr(ADDR_CTRL1, 8'h10, RESP_OKAY);
        idle;
        chk("ctl", 10'h288, ctl);
        chk("ratio", {11'h001, 7'h01}, rat);
        // high range with the reference already running
        slow <= 1'h0;
        rst;
        wr(ADDR_CTRL1, 8'h58, RESP_OKAY);
        idle;
        chk("ctl", 10'h32A, ctl);
        chk("ratio", {11'h004, 7'h01}, rat);
        rck(ADDR_STATUS, 32'h1F, 32'h0D, RESP_OKAY);
        conclude;
    end
endmodule : fcg_clock_control_bench

bind fcg_clock_control fcg_clock_control_asserts chk_u (.*);
